//--- rmi_pkg.sv
// Package for the register move instruction execution unit
package rmi_pkg;
   // ==========================================
   // Instruction word layout
   localparam int RMI_WORD_W     = 14;
   localparam int RMI_DATA_W     = 8;
   localparam int RMI_ADDR_W     = 7;
   localparam int RMI_FILE_DEPTH = 128;
   localparam int RMI_OPC_MSB    = 11;
   localparam int RMI_OPC_LSB    = 8;
   localparam int RMI_DEST_BIT   = 7;
   localparam int RMI_TOP_MSB    = 13;
   localparam int RMI_TOP_LSB    = 12;
   localparam int RMI_LIT_OPC_MSB = 11;
   localparam int RMI_LIT_OPC_LSB = 10;
   // ==========================================
   // Opcode encodings
   localparam logic [1:0] RMI_TOP_BYTE_OP = 2'h0;
   localparam logic [1:0] RMI_TOP_LIT_OP  = 2'h3;
   localparam logic [3:0] RMI_OPC_COPY    = 4'h8;
   localparam logic [3:0] RMI_OPC_STORE   = 4'h0;
   localparam logic [1:0] RMI_LIT_OPC_LD  = 2'h0;
   // ==========================================
   // Reset values
   localparam logic [7:0] RMI_ACC_RST  = 8'h00;
   localparam logic       RMI_ZERO_RST = 1'b0;

   // Four phases of one instruction cycle, Gray coded
   typedef enum logic [1:0]
   {
      RMI_PH_DECODE  = 2'b00,
      RMI_PH_READ    = 2'b01,
      RMI_PH_PROCESS = 2'b11,
      RMI_PH_WRITE   = 2'b10
   } rmi_phase_type;

   typedef enum logic [1:0]
   {
      RMI_OP_NONE  = 2'h0,
      RMI_OP_COPY  = 2'h1,
      RMI_OP_STORE = 2'h2,
      RMI_OP_LOAD  = 2'h3
   } rmi_op_type;

   // Write port into the file register memory
   typedef struct packed
   {
      logic       en;
      logic [6:0] addr;
      logic [7:0] data;
   } rmi_wr_type;
endpackage

//--- rmi_file_mem.sv
// File register memory with registered read data
module rmi_file_mem #(
   parameter int DATA_W = 8,
   parameter int ADDR_W = 7,
   parameter int DEPTH  = 128
)(
   // Clock
   input  wire logic              clk_sys,
   // Read port
   input  wire logic [ADDR_W-1:0] rd_addr,
   output logic      [DATA_W-1:0] rd_data,
   // Write port
   input  wire logic              wr_en,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [DATA_W-1:0] wr_data
);
   // ==========================================
   // Storage; contents are not reset, as in static RAM
   logic [DATA_W-1:0] mem_reg [DEPTH];

   always_ff @(posedge clk_sys)
   begin
      if (wr_en)
      begin
         mem_reg[wr_addr] <= wr_data;
      end
      rd_data <= mem_reg[rd_addr];
   end
endmodule

//--- rmi_move_unit.sv
// Execution unit for the copy, store and literal load move instructions
module rmi_move_unit #(
   parameter int DATA_W = rmi_pkg::RMI_DATA_W,
   parameter int ADDR_W = rmi_pkg::RMI_ADDR_W,
   parameter int DEPTH  = rmi_pkg::RMI_FILE_DEPTH
)(
   // Clock and reset
   input  wire logic                           clk_sys,
   input  wire logic                           rst,
   // Instruction fetch
   input  wire logic                           instr_valid,
   input  wire logic [rmi_pkg::RMI_WORD_W-1:0] instr_word,
   // Instruction status
   output logic                                instr_ready,
   output logic                                instr_done,
   output logic                                instr_illegal,
   output rmi_pkg::rmi_phase_type              phase,
   // Core state
   output logic [7:0]                          acc_value,
   output logic                                zero_flag,
   // Destination write observation
   output rmi_pkg::rmi_wr_type                 file_wr
);
   import rmi_pkg::*;

   // ==========================================
   // Phase sequencer
   rmi_phase_type phase_reg, phase_next;
   rmi_op_type    op_reg, op_next;
   logic [RMI_WORD_W-1:0] word_reg, word_next;
   logic          busy_reg, busy_next;
   // Ready kept in its own flop so the port needs no inverter
   logic          rdy_reg;
   logic          done_reg, done_next;
   logic          ill_reg, ill_next;
   logic [7:0]    acc_reg, acc_next;
   logic          zero_reg, zero_next;
   logic [7:0]    res_reg, res_next;
   rmi_wr_type    wr_reg, wr_next;
   logic [7:0]    mem_rd;
   logic [ADDR_W-1:0] addr_now;
   rmi_op_type    op_dec;
   logic          dest_now;

   assign addr_now = word_reg[ADDR_W-1:0];
   assign dest_now = word_reg[RMI_DEST_BIT];

   // Decode of the incoming word
   always_comb
   begin
      op_dec = RMI_OP_NONE;
      if (instr_word[RMI_TOP_MSB:RMI_TOP_LSB] == RMI_TOP_BYTE_OP &&
          instr_word[RMI_OPC_MSB:RMI_OPC_LSB] == RMI_OPC_COPY)
      begin
         op_dec = RMI_OP_COPY;
      end
      else if (instr_word[RMI_TOP_MSB:RMI_TOP_LSB] == RMI_TOP_BYTE_OP &&
               instr_word[RMI_OPC_MSB:RMI_OPC_LSB] == RMI_OPC_STORE &&
               instr_word[RMI_DEST_BIT])
      begin
         op_dec = RMI_OP_STORE;
      end
      else if (instr_word[RMI_TOP_MSB:RMI_TOP_LSB] == RMI_TOP_LIT_OP &&
               instr_word[RMI_LIT_OPC_MSB:RMI_LIT_OPC_LSB] == RMI_LIT_OPC_LD)
      begin
         op_dec = RMI_OP_LOAD;
      end
   end

   always_comb
   begin
      phase_next = phase_reg;
      op_next    = op_reg;
      word_next  = word_reg;
      busy_next  = busy_reg;
      done_next  = 1'b0;
      ill_next   = 1'b0;
      acc_next   = acc_reg;
      zero_next  = zero_reg;
      res_next   = res_reg;
      wr_next    = '0;
      case (phase_reg)
         RMI_PH_DECODE:
         begin
            // Words outside the move group are flagged and dropped
            if (instr_valid)
            begin
               word_next = instr_word;
               op_next   = op_dec;
               if (op_dec == RMI_OP_NONE)
               begin
                  ill_next = 1'b1;
               end
               else
               begin
                  busy_next  = 1'b1;
                  phase_next = RMI_PH_READ;
               end
            end
         end
         RMI_PH_READ:
         begin
            // Memory read data arrives one edge after the address
            phase_next = RMI_PH_PROCESS;
         end
         RMI_PH_PROCESS:
         begin
            case (op_reg)
               RMI_OP_COPY:  res_next = mem_rd;
               RMI_OP_STORE: res_next = acc_reg;
               RMI_OP_LOAD:  res_next = word_reg[DATA_W-1:0];
               default:      res_next = res_reg;
            endcase
            phase_next = RMI_PH_WRITE;
         end
         RMI_PH_WRITE:
         begin
            case (op_reg)
               RMI_OP_COPY:
               begin
                  if (dest_now)
                  begin
                     wr_next.en   = 1'b1;
                     wr_next.addr = addr_now;
                     wr_next.data = res_reg;
                  end
                  else
                  begin
                     acc_next = res_reg;
                  end
                  zero_next = (res_reg == 8'h00);
               end
               RMI_OP_STORE:
               begin
                  // Flags left as they were
                  wr_next.en   = 1'b1;
                  wr_next.addr = addr_now;
                  wr_next.data = res_reg;
               end
               RMI_OP_LOAD:
               begin
                  acc_next = res_reg;
               end
               default:
               begin
                  acc_next = acc_reg;
               end
            endcase
            done_next  = 1'b1;
            busy_next  = 1'b0;
            phase_next = RMI_PH_DECODE;
         end
         default:
         begin
            phase_next = RMI_PH_DECODE;
            busy_next  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         phase_reg <= RMI_PH_DECODE;
         op_reg    <= RMI_OP_NONE;
         word_reg  <= '0;
         busy_reg  <= 1'b0;
         rdy_reg   <= 1'b1;
         done_reg  <= 1'b0;
         ill_reg   <= 1'b0;
         acc_reg   <= RMI_ACC_RST;
         zero_reg  <= RMI_ZERO_RST;
         res_reg   <= 8'h00;
         wr_reg    <= '0;
      end
      else
      begin
         phase_reg <= phase_next;
         op_reg    <= op_next;
         word_reg  <= word_next;
         busy_reg  <= busy_next;
         rdy_reg   <= ~busy_next;
         done_reg  <= done_next;
         ill_reg   <= ill_next;
         acc_reg   <= acc_next;
         zero_reg  <= zero_next;
         res_reg   <= res_next;
         wr_reg    <= wr_next;
      end
   end

   // ==========================================
   // File register memory
   rmi_file_mem #(
      .DATA_W (DATA_W),
      .ADDR_W (ADDR_W),
      .DEPTH  (DEPTH)
   ) u_mem (
      .clk_sys (clk_sys),
      .rd_addr (addr_now),
      .rd_data (mem_rd),
      .wr_en   (wr_next.en),
      .wr_addr (wr_next.addr),
      .wr_data (wr_next.data)
   );

   // ==========================================
   // Outputs, all registered
   assign instr_ready   = rdy_reg;
   assign instr_done    = done_reg;
   assign instr_illegal = ill_reg;
   assign phase         = phase_reg;
   assign acc_value     = acc_reg;
   assign zero_flag     = zero_reg;
   assign file_wr       = wr_reg;
endmodule

//--- rmi_move_unit_props.sv
// Port checker for the move instruction unit
module rmi_move_unit_chk
   import rmi_pkg::*;
(
   // Clock and reset
   input wire logic          clk_sys,
   input wire logic          rst,
   // Instruction side
   input wire logic          instr_valid,
   input wire logic [13:0]   instr_word,
   input wire logic          instr_ready,
   input wire logic          instr_done,
   input wire rmi_phase_type phase,
   // Core state
   input wire logic [7:0]    acc_value,
   input wire logic          zero_flag,
   input wire rmi_wr_type    file_wr
);
   // ==========================================
   // Decode of taken words
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire logic tk = instr_valid && instr_ready;
   wire logic cp = tk && instr_word[13:8] == 6'h08;
   wire logic st = tk && instr_word[13:7] == 7'h01;
   wire logic ld = tk && instr_word[13:10] == 4'hc;
   // Last write seen, so a copy can be tied to known contents
   logic [6:0] la_reg;
   logic [7:0] ld_reg;
   logic       lv_reg;
   always_ff @(posedge clk_sys)
   begin
      if (rst) lv_reg <= 1'b0;
      else if (file_wr.en) {lv_reg, la_reg, ld_reg} <= {1'b1, file_wr.addr, file_wr.data};
   end
   // A write shown this cycle is newer than the captured one, for back to back words
   wire logic       cv = file_wr.en || lv_reg;
   wire logic [6:0] ca = file_wr.en ? file_wr.addr : la_reg;
   wire logic [7:0] cd = file_wr.en ? file_wr.data : ld_reg;
   // ==========================================
   // Properties
   property p_phases;
      cp || st || ld |=> phase == RMI_PH_READ ##1 phase == RMI_PH_PROCESS ##1 phase == RMI_PH_WRITE
         ##1 phase == RMI_PH_DECODE && instr_done && instr_ready;
   endproperty
   a_phases: assert property (p_phases) else $error("phase sequence wrong");
   property p_load;
      ld |-> ##4 acc_value == $past(instr_word[7:0], 4) && zero_flag == $past(zero_flag, 4);
   endproperty
   a_load: assert property (p_load) else $error("literal load wrong");
   property p_value;
      cp && cv && instr_word[6:0] == ca |-> ##4 (file_wr.en ? file_wr.data : acc_value) == $past(cd, 4);
   endproperty
   a_value: assert property (p_value) else $error("copied value altered");
   property p_keep_file;
      cp && !instr_word[7] |-> ##4 !file_wr.en;
   endproperty
   a_keep_file: assert property (p_keep_file) else $error("copy to acc wrote file");
   property p_wback;
      cp && instr_word[7] |-> ##4 file_wr.en && file_wr.addr == $past(instr_word[6:0], 4) && $stable(acc_value);
   endproperty
   a_wback: assert property (p_wback) else $error("write back wrong");
   property p_zero;
      cp |-> ##4 zero_flag == ((file_wr.en ? file_wr.data : acc_value) == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_store;
      st |-> ##4 file_wr == {1'b1, $past(instr_word[6:0], 4), $past(acc_value, 4)} && zero_flag == $past(zero_flag, 4);
   endproperty
   a_store: assert property (p_store) else $error("store wrong");
   c_copy_acc: cover property (cp && !instr_word[7]);
   c_copy_file: cover property (cp && instr_word[7]);
   c_store: cover property (st);
endmodule
bind rmi_move_unit rmi_move_unit_chk u_chk (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
   .instr_word(instr_word), .instr_ready(instr_ready), .instr_done(instr_done), .phase(phase),
   .acc_value(acc_value), .zero_flag(zero_flag), .file_wr(file_wr));

//--- rmi_move_unit_tb.sv
// Self-checking bench for the move instruction unit
module rmi_move_unit_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import rmi_pkg::*;
   logic          clk_sys = 1'b0;
   logic          rst = 1'b1;
   logic          instr_valid = 1'b0;
   logic [13:0]   instr_word = 14'h0000;
   logic          instr_ready, instr_done, instr_illegal, zero_flag;
   logic [7:0]    acc_value;
   rmi_phase_type phase;
   rmi_wr_type    file_wr;
   int            errors = 0;
   int            n_tests = 0;
   rmi_move_unit uut (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
      .instr_ready(instr_ready), .instr_done(instr_done), .instr_illegal(instr_illegal), .phase(phase),
      .acc_value(acc_value), .zero_flag(zero_flag), .file_wr(file_wr));
   initial forever #20 clk_sys = ~clk_sys;
   // ==========================================
   // Helpers
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // The read and process cycles carry a stray load of ff so every run also proves it is ignored
   task exec(input logic [13:0] w, input logic [9:0] e_st, input logic [15:0] e_wr);
      @(negedge clk_sys);
      instr_valid = 1'b1;
      instr_word = w;
      @(negedge clk_sys);
      instr_word = 14'h30ff;
      chk({13'h0000, instr_ready, phase}, {13'h0000, 1'b0, RMI_PH_READ});
      repeat (2) @(negedge clk_sys);
      instr_valid = 1'b0;
      @(negedge clk_sys);
      chk({6'h00, instr_done, zero_flag, acc_value}, {6'h00, e_st});
      chk(file_wr, e_wr);
   endtask
   task summarize;
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task t_load_store;
      exec(14'h305a, 10'h25a, 16'h0000);
      exec(14'h0090, 10'h25a, 16'h905a);
      exec(14'h3000, 10'h200, 16'h0000);
      exec(14'h0091, 10'h200, 16'h9100);
      $display("load and store done");
   endtask
   task t_copy;
      exec(14'h0811, 10'h300, 16'h0000);
      exec(14'h305a, 10'h35a, 16'h0000);
      exec(14'h00ff, 10'h35a, 16'hff5a);
      exec(14'h0890, 10'h25a, 16'h905a);
      exec(14'h3000, 10'h200, 16'h0000);
      exec(14'h087f, 10'h25a, 16'h0000);
      $display("copy done");
   endtask
   task t_illegal;
      @(negedge clk_sys);
      instr_valid = 1'b1;
      instr_word = 14'h0011;
      @(negedge clk_sys);
      instr_valid = 1'b0;
      chk({14'h0000, instr_illegal, instr_ready}, 16'h0003);
      repeat (4) @(negedge clk_sys);
      chk({7'h00, file_wr.en, acc_value}, 16'h005a);
      $display("illegal word done");
   endtask
   initial
   begin
      repeat (6) @(negedge clk_sys);
      rst = 1'b0;
      t_load_store();
      t_copy();
      t_illegal();
      summarize();
   end
   initial
   begin
      #40000;
      errors++;
      summarize();
   end
endmodule
